// [verilog/radio_frame_buffer.v]
// Overview of operation
// - Power field bits 3:0 set transmit level
// - Auto checksum bit replaces frame check bytes
// - 128-byte memory, host and baseband ports
// - One frame held, shared for transmit/receive
// - Buffer access only while supply regulator on
// - Contents kept until new frame, sleep or power-on
// - Sleep powers off buffer, data lost
// - Receive overwrite starts 32 us after start
// - Auto-retry receive frames never stored
// - Store payload plus link quality, no length
// - Frame mode prefixes length; SRAM mode hides it
// - Payloads of one byte accepted
// - Read violation when host count >= baseband count
// - Write violation when host count <= baseband count
// - Violations reported only in frame mode
// - Underrun meaningful from 64 us after start
// - New frame during read raises underrun and start
`timescale 1ns/100ps
`include "radio_frame_buffer_defs.vh"

module radio_frame_buffer #(
  parameter RX_WR_DELAY = `RX_WR_US * `CLK_MHZ,   // Cycles before overwrite
  parameter UR_VALID_DLY = `UR_VALID_US * `CLK_MHZ // Cycles before underrun valid
) (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        clk_en,
  input  wire [31:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        bb_clk,
  input  wire        bb_rx_start,
  input  wire        bb_rx_valid,
  input  wire        bb_rx_end,
  input  wire [7:0]  bb_rx_byte,
  input  wire [7:0]  bb_rx_len,
  input  wire [7:0]  bb_lqi,
  input  wire        bb_tx_req,
  input  wire        sleep_tx_trigger_pin,
  input  wire        sleep_mode,
  input  wire        power_on_state,
  input  wire        rx_enable,
  input  wire        auto_retry_tx_state,
  output reg  [7:0]  tx_byte,
  output reg         tx_strobe,
  output reg         tx_busy,
  output wire [3:0]  tx_power_level,
  output reg         frame_start_irq,
  output reg         frame_end_irq,
  output reg         buffer_underrun_irq,
  output wire        underrun_valid
);

  // One-hot baseband states
  localparam ST_IDLE = 4'b0001;
  localparam ST_WAIT = 4'b0010;
  localparam ST_RX   = 4'b0100;
  localparam ST_TX   = 4'b1000;

  // Checksum step, reflected polynomial, one byte
  function [15:0] fcs_step;
    input [15:0] crc;
    input [7:0]  dat;
    integer      i;
    reg   [15:0] c;
    begin
      c = crc;
      for (i = 0; i < 8; i = i + 1) begin
        if (c[0] ^ dat[i])
          c = (c >> 1) ^ 16'h8408;
        else
          c = c >> 1;
      end
      fcs_step = c;
    end
  endfunction

  // Pin synchronisers, two stages
  reg  [33:0] sync1_q;                  // First stage
  reg  [33:0] sync2_q;                  // Second stage, read by logic
  wire [33:0] pins = {bb_clk, bb_rx_start, bb_rx_valid, bb_rx_end, bb_rx_byte,
                      bb_rx_len, bb_lqi, bb_tx_req, sleep_tx_trigger_pin, sleep_mode,
                      power_on_state, rx_enable, auto_retry_tx_state};
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      sync1_q <= 34'h000000000;
      sync2_q <= 34'h000000000;
    end else if (clk_en) begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  // Synchronised views
  wire       s_bclk  = sync2_q[33];
  wire       s_start = sync2_q[32];
  wire       s_valid = sync2_q[31];
  wire       s_end   = sync2_q[30];
  wire [7:0] s_byte  = sync2_q[29:22];
  wire [7:0] s_len   = sync2_q[21:14];
  wire [7:0] s_lqi   = sync2_q[13:6];   // Link quality, aligned with frame end
  wire       s_treq  = sync2_q[5];
  wire       s_trig  = sync2_q[4];
  wire       s_sleep = sync2_q[3];
  wire       s_pon   = sync2_q[2];
  wire       s_rxen  = sync2_q[1];
  wire       s_aret  = sync2_q[0];

  // Edge detection on synchronised pins
  reg        bclk_d_q;                  // Delayed link clock
  reg        trig_d_q;                  // Delayed transmit trigger
  wire       bedge   = s_bclk & ~bclk_d_q;
  wire       trig_up = s_trig & ~trig_d_q;
  wire       pwr_ok  = ~s_sleep & ~s_pon; // Regulator active
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      bclk_d_q <= 1'b0;
      trig_d_q <= 1'b0;
    end else if (clk_en) begin
      bclk_d_q <= s_bclk;
      trig_d_q <= s_trig;
    end
  end

  // Storage and control state
  reg [7:0]  mem [0:`BUF_DEPTH-1];      // Frame store
  reg [7:0]  txpwr_q;                   // tx_power_control
  reg        sram_q;                    // SRAM access mode
  reg [6:0]  sram_addr_q;               // SRAM start address
  reg [7:0]  hcnt_q;                    // Host address counter
  reg        hfirst_q;                  // Next frame access is length
  reg        hrd_q;                     // Burst direction is read
  reg        hact_q;                    // Burst in progress
  reg [7:0]  bcnt_q;                    // Baseband address counter
  reg [7:0]  len_q;                     // Frame length octet
  reg        valid_q;                   // Contents valid
  reg        ur_q;                      // Sticky underrun flag
  reg [3:0]  st_q;                      // Baseband state
  reg [15:0] tmr_q;                     // Delay after frame start
  reg [15:0] urt_q;                     // Underrun-valid timer
  reg        urv_q;                     // Underrun-valid level
  reg [15:0] crc_q;                     // Running checksum

  assign tx_power_level = txpwr_q[`PWR_LVL_MSB:`PWR_LVL_LSB];
  assign underrun_valid = urv_q;

  // APB decode
  wire [7:0] idx    = paddr[9:2];
  wire       setup  = psel & ~penable;
  wire       access = psel & penable & clk_en;
  wire       wr     = access & pwrite;
  wire       rd     = access & ~pwrite;
  wire       hit    = (idx == `IDX_TX_POWER_LEVEL) | (idx == `IDX_BUF_CTRL) |
                      (idx == `IDX_BUF_DATA) | (idx == `IDX_BUF_STAT);
  wire       dat_ok = pwr_ok & (idx == `IDX_BUF_DATA);
  wire       dwr    = wr & dat_ok;
  wire       drd    = rd & dat_ok;
  wire       burst  = wr & (idx == `IDX_BUF_CTRL) & pwdata[`CTRL_START_BIT];
  wire [6:0] haddr  = hcnt_q[6:0];

  // Zero-wait slave; error on unmapped or powered-down data port
  assign pready  = psel & penable;
  assign pslverr = psel & penable & (~hit | ((idx == `IDX_BUF_DATA) & ~pwr_ok));

  // Read data captured in the setup cycle
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (clk_en & setup) begin
      case (idx)
        `IDX_TX_POWER_LEVEL:   prdata <= {24'h000000, txpwr_q};
        `IDX_BUF_CTRL: prdata <= {17'h00000, sram_addr_q, 6'h00, sram_q, 1'b0};
        `IDX_BUF_STAT: prdata <= {16'h0000, len_q, 6'h00, valid_q, ur_q};
        `IDX_BUF_DATA: begin
          if (~pwr_ok | ~valid_q)
            prdata <= 32'h00000000;
          else if (hfirst_q & ~sram_q)
            prdata <= {24'h000000, len_q};
          else
            prdata <= {24'h000000, mem[haddr]};
        end
        default:       prdata <= 32'h00000000;
      endcase
    end
  end

  // Violation checks on host data accesses
  wire fb_data = ~sram_q & ~hfirst_q;   // Payload access in frame mode
  wire rd_viol = drd & fb_data & (st_q == ST_RX) & (hcnt_q >= bcnt_q);
  wire wr_viol = dwr & fb_data & (st_q == ST_TX) & (hcnt_q <= bcnt_q);
  wire new_rx  = bedge & s_start & s_rxen & ~s_aret & pwr_ok & (st_q != ST_TX);
  wire late_rd = new_rx & hact_q & hrd_q & ~sram_q;
  wire ur_set  = (rd_viol | wr_viol | late_rd) & ~sram_q;

  // Host registers and host counter
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      txpwr_q     <= `RST_TX_POWER_LEVEL;
      sram_q      <= 1'b0;
      sram_addr_q <= 7'h00;
      hcnt_q      <= 8'h00;
      hfirst_q    <= 1'b1;
      hrd_q       <= 1'b0;
      hact_q      <= 1'b0;
      ur_q        <= 1'b0;
    end else if (clk_en) begin
      // Software writes; power field and checksum enable
      if (wr & (idx == `IDX_TX_POWER_LEVEL))
        txpwr_q <= pwdata[7:0];
      if (wr & (idx == `IDX_BUF_CTRL)) begin
        sram_q      <= pwdata[`CTRL_SRAM_BIT];
        sram_addr_q <= pwdata[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB];
      end
      // New burst restarts host counter
      if (burst) begin
        hcnt_q   <= pwdata[`CTRL_SRAM_BIT] ?
                    {1'b0, pwdata[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB]} : 8'h00;
        hfirst_q <= ~pwdata[`CTRL_SRAM_BIT];
        hact_q   <= 1'b0;
      end else if (dwr | drd) begin
        hact_q <= 1'b1;
        hrd_q  <= drd;
        if (hfirst_q & ~sram_q)
          hfirst_q <= 1'b0;                        // Length octet done
        else
          hcnt_q <= {1'b0, haddr + 7'h01};
      end
      // Sticky underrun; set wins over clear
      if (ur_set)
        ur_q <= 1'b1;
      else if (wr & (idx == `IDX_BUF_STAT) & pwdata[`STAT_UR_BIT])
        ur_q <= 1'b0;
    end
  end

  // Underrun pulse output
  always @(posedge ref_clk) begin
    if (sys_rst)
      buffer_underrun_irq <= 1'b0;
    else if (clk_en)
      buffer_underrun_irq <= ur_set;
  end

  // Transmit byte selection with checksum substitution
  wire       fcs_on  = txpwr_q[`FCS_AUTO_BIT];
  wire [7:0] fcs_lo  = len_q - 8'h02;
  wire       in_fcs  = fcs_on & (len_q >= 8'h02) & (bcnt_q >= fcs_lo);
  wire [7:0] tx_sel  = ~in_fcs ? mem[bcnt_q[6:0]] :
                       (bcnt_q == fcs_lo) ? crc_q[7:0] : crc_q[15:8];
  wire       tx_last = (bcnt_q + 8'h01 >= len_q);  // One-byte frames end at once

  // Baseband state machine
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q            <= ST_IDLE;
      bcnt_q          <= 8'h00;
      tmr_q           <= 16'h0000;
      urt_q           <= 16'h0000;
      urv_q           <= 1'b0;
      crc_q           <= `FCS_INIT;
      len_q           <= 8'h00;
      valid_q         <= 1'b0;
      tx_byte         <= 8'h00;
      tx_strobe       <= 1'b0;
      tx_busy         <= 1'b0;
      frame_start_irq <= 1'b0;
      frame_end_irq   <= 1'b0;
    end else if (clk_en) begin
      tx_strobe       <= 1'b0;
      frame_start_irq <= 1'b0;
      frame_end_irq   <= 1'b0;
      // Underrun-valid timer after frame start
      if (new_rx) begin
        urt_q <= 16'h0000;
        urv_q <= 1'b0;
      end else if (~urv_q & (st_q != ST_IDLE)) begin
        if (urt_q >= UR_VALID_DLY[15:0] - 16'h0001)
          urv_q <= 1'b1;
        urt_q <= urt_q + 16'h0001;
      end
      // Host writes length to begin a new transmit frame
      if (dwr & hfirst_q & ~sram_q) begin
        len_q   <= pwdata[7:0];
        valid_q <= 1'b1;
      end
      if (~pwr_ok) begin
        // Sleep or power-on: buffer unpowered, frame lost
        st_q    <= ST_IDLE;
        valid_q <= 1'b0;
        tx_busy <= 1'b0;
      end else begin
        case (st_q)
          ST_IDLE: begin
            if (new_rx) begin
              st_q            <= ST_WAIT;
              tmr_q           <= 16'h0000;
              frame_start_irq <= 1'b1;
            end else if (trig_up) begin
              st_q    <= ST_TX;
              bcnt_q  <= 8'h00;
              crc_q   <= `FCS_INIT;
              tx_busy <= 1'b1;
            end
          end
          ST_WAIT: begin
            // Hold off overwrite until delay elapses
            if (tmr_q >= RX_WR_DELAY[15:0] - 16'h0001) begin
              st_q    <= ST_RX;
              bcnt_q  <= 8'h00;
              valid_q <= 1'b1;
            end else begin
              tmr_q <= tmr_q + 16'h0001;
            end
          end
          ST_RX: begin
            // Payload bytes then link quality; length kept apart
            if (bedge & s_end) begin
              mem[bcnt_q[6:0]] <= s_lqi;
              len_q            <= s_len;
              frame_end_irq    <= 1'b1;
              st_q             <= ST_IDLE;
            end else if (bedge & s_valid & ~bcnt_q[7]) begin
              mem[bcnt_q[6:0]] <= s_byte;
              bcnt_q           <= bcnt_q + 8'h01;
            end
          end
          ST_TX: begin
            // One byte per baseband request
            if (bedge & s_treq) begin
              tx_byte   <= tx_sel;
              tx_strobe <= 1'b1;
              if (~in_fcs)
                crc_q <= fcs_step(crc_q, mem[bcnt_q[6:0]]);
              if (tx_last) begin
                st_q    <= ST_IDLE;
                tx_busy <= 1'b0;
              end else begin
                bcnt_q <= bcnt_q + 8'h01;
              end
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
      // Host payload write into shared store
      if (dwr & ~(hfirst_q & ~sram_q) & ~(st_q == ST_RX))
        mem[haddr] <= pwdata[7:0];
    end
  end

endmodule // radio_frame_buffer

// [verilog/radio_frame_buffer_defs.vh]
`ifndef RADIO_FRAME_BUFFER_DEFS_VH
`define RADIO_FRAME_BUFFER_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_TX_POWER_LEVEL      8'h05
`define IDX_BUF_CTRL    8'h08
`define IDX_BUF_DATA    8'h09
`define IDX_BUF_STAT    8'h0A

// Reset values
`define RST_TX_POWER_LEVEL      8'h00
`define RST_BUF_CTRL    8'h00

// tx_power_control fields
`define FCS_AUTO_BIT    7
`define PWR_LVL_MSB     3
`define PWR_LVL_LSB     0

// buffer control fields
`define CTRL_START_BIT  0
`define CTRL_SRAM_BIT   1
`define CTRL_ADDR_MSB   14
`define CTRL_ADDR_LSB   8

// buffer status fields
`define STAT_UR_BIT     0
`define STAT_VALID_BIT  1
`define STAT_LEN_LSB    8

// Buffer geometry
`define BUF_DEPTH       128
`define BUF_AW          7

// Timing: figures in microseconds, clock in MHz
`define CLK_MHZ         200
`define RX_WR_US        32
`define UR_VALID_US     64

// Checksum seed
`define FCS_INIT        16'h0000

`endif

// [verification/radio_frame_buffer_sva.sv]
`timescale 1ns/100ps
// Port-level checks of the frame buffer block
module radio_frame_buffer_sva (
  input wire        ref_clk,
  input wire        sys_rst,
  input wire [31:0] paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire        bb_clk,
  input wire        bb_rx_start,
  input wire        bb_tx_req,
  input wire        sleep_mode,
  input wire        power_on_state,
  input wire        rx_enable,
  input wire        auto_retry_tx_state,
  input wire        tx_strobe,
  input wire        tx_busy,
  input wire [3:0]  tx_power_level,
  input wire        frame_start_irq,
  input wire        frame_end_irq,
  input wire        underrun_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire       acc    = psel && penable;                 // Access phase
  wire [7:0] idx    = paddr[9:2];                      // Register index
  wire [3:0] pw_lvl = pwdata[3:0];                     // Written power code
  wire       off    = sleep_mode || power_on_state;    // Buffer unpowered
  wire       rx_ok  = rx_enable && !auto_retry_tx_state && !off && !tx_busy;
  property p_zero_wait; pready == (psel && penable); endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("pready not zero wait");
  property p_power; acc && pwrite && idx == 8'h05 |=> tx_power_level == $past(pw_lvl); endproperty
  a_power: assert property (p_power) else $error("power level not updated");
  property p_unmapped; acc && !(idx inside {8'h05, 8'h08, 8'h09, 8'h0A}) |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
  property p_unpowered; acc && idx == 8'h09 && off && $past(off, 6) |-> pslverr; endproperty
  a_unpowered: assert property (p_unpowered) else $error("data access while unpowered");
  property p_start;
    $rose(bb_clk) && bb_rx_start && rx_ok |-> ##[2:6] frame_start_irq;
  endproperty
  a_start: assert property (p_start) else $error("frame start not flagged");
  property p_aret; auto_retry_tx_state && $past(auto_retry_tx_state, 8) |-> !frame_start_irq; endproperty
  a_aret: assert property (p_aret) else $error("frame taken in auto retry");
  property p_strobe; tx_strobe |-> $past(tx_busy) ##1 !tx_strobe; endproperty
  a_strobe: assert property (p_strobe) else $error("bad transmit strobe");
  property p_tx; $rose(bb_clk) && bb_tx_req && tx_busy |-> ##[2:7] tx_strobe; endproperty
  a_tx: assert property (p_tx) else $error("transmit byte not served");
  property p_uv; frame_start_irq |=> !underrun_valid [*8]; endproperty
  a_uv: assert property (p_uv) else $error("underrun valid too early");
  property p_end; frame_end_irq |=> !frame_end_irq; endproperty
  a_end: assert property (p_end) else $error("frame end not a pulse");
  property p_reset; disable iff (1'b0) sys_rst |=> !tx_busy && !tx_strobe && !frame_start_irq;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  c_start: cover property (frame_start_irq);
  c_tx: cover property (tx_strobe ##[1:20] tx_strobe);
  c_err: cover property (acc && pslverr);
endmodule // radio_frame_buffer_sva

bind radio_frame_buffer radio_frame_buffer_sva chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .bb_clk(bb_clk),
  .bb_rx_start(bb_rx_start), .bb_tx_req(bb_tx_req), .sleep_mode(sleep_mode),
  .power_on_state(power_on_state), .rx_enable(rx_enable),
  .auto_retry_tx_state(auto_retry_tx_state), .tx_strobe(tx_strobe), .tx_busy(tx_busy),
  .tx_power_level(tx_power_level), .frame_start_irq(frame_start_irq),
  .frame_end_irq(frame_end_irq), .underrun_valid(underrun_valid));

// [verification/baseband_model.sv]
`timescale 1ns/100ps
// Baseband side; its link clock runs only inside frames
module baseband_model (
  output reg       bb_clk,
  output reg       bb_rx_start,
  output reg       bb_rx_valid,
  output reg       bb_rx_end,
  output reg [7:0] bb_rx_byte,
  output reg [7:0] bb_rx_len,
  output reg [7:0] bb_lqi,
  output reg       bb_tx_req
);
  // Idle levels at time zero
  initial begin
    {bb_clk, bb_rx_start, bb_rx_valid, bb_rx_end, bb_tx_req} = 5'h00;
    {bb_rx_byte, bb_rx_len, bb_lqi} = 24'h5A3CC3;
  end
  // One 64 ns link clock period, data changes while low
  task cyc;
    begin
      #32 bb_clk = 1'b1;
      #32 bb_clk = 1'b0;
    end
  endtask
  // Received frame: start, delay, bytes, end with length and quality
  task rx_frame(input [7:0] n, input [31:0] d, input [7:0] q);
    integer i;
    begin
      bb_rx_start = 1'b1;
      cyc;
      bb_rx_start = 1'b0;
      repeat (4) cyc;
      for (i = 0; i < n; i = i + 1) begin
        bb_rx_valid = 1'b1;
        bb_rx_byte  = d[8*i+:8];
        cyc;
      end
      bb_rx_valid = 1'b0;
      bb_rx_byte  = ~bb_rx_byte;
      bb_rx_end   = 1'b1;
      bb_rx_len   = n;
      bb_lqi      = q;
      cyc;
      bb_rx_end   = 1'b0;
      bb_rx_len   = ~bb_rx_len;
      bb_lqi      = ~bb_lqi;
    end
  endtask
  // Pull n transmit bytes, one per link clock
  task tx_pull(input integer n);
    begin
      bb_tx_req = 1'b1;
      repeat (n) cyc;
      bb_tx_req = 1'b0;
      cyc;
    end
  endtask
endmodule // baseband_model

// [verification/radio_frame_buffer_test.sv]
`timescale 1ns/100ps
module radio_frame_buffer_test;
  reg         ref_clk = 1'b0;            // 200 MHz clock
  reg         sys_rst = 1'b1;            // Held 12 cycles
  reg  [31:0] paddr   = 32'h0;
  reg  [31:0] pwdata  = 32'h0;
  reg         psel    = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite  = 1'b0;
  reg         trig    = 1'b0;            // Transmit trigger pin
  reg         slp     = 1'b0;            // Sleep state
  reg         pon     = 1'b0;            // Power-on state
  reg         rx_en   = 1'b0;            // Receive state
  reg         aret    = 1'b0;            // Auto retry state
  wire [31:0] prdata;
  wire        pready, pslverr, bb_clk, bb_rx_start, bb_rx_valid, bb_rx_end, bb_tx_req;
  wire [7:0]  bb_rx_byte, bb_rx_len, bb_lqi, tx_byte;
  wire [3:0]  tx_power_level;
  wire        tx_strobe, tx_busy, fs_irq, fe_irq, ur_irq, ur_valid;
  integer     n_mismatch = 0;
  integer     tests_run  = 0;
  integer     n_ur       = 0;            // Underrun pulses seen
  integer     n_fs       = 0;            // Frame start pulses seen
  integer     n_fe       = 0;            // Frame end pulses seen
  integer     seed       = 32'h05e413d9;
  integer     i;
  reg  [32:0] rdq[$];                    // Expected {pslverr, prdata}
  reg  [7:0]  txq[$];                    // Expected transmit bytes
  reg  [7:0]  b[0:3];                    // Random frame bytes
  reg  [15:0] crc;
  always #2.5 ref_clk = ~ref_clk;
  radio_frame_buffer #(.RX_WR_DELAY(20), .UR_VALID_DLY(40)) DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bb_clk(bb_clk), .bb_rx_start(bb_rx_start), .bb_rx_valid(bb_rx_valid),
    .bb_rx_end(bb_rx_end), .bb_rx_byte(bb_rx_byte), .bb_rx_len(bb_rx_len), .bb_lqi(bb_lqi),
    .bb_tx_req(bb_tx_req), .sleep_tx_trigger_pin(trig), .sleep_mode(slp),
    .power_on_state(pon), .rx_enable(rx_en), .auto_retry_tx_state(aret), .tx_byte(tx_byte),
    .tx_strobe(tx_strobe), .tx_busy(tx_busy), .tx_power_level(tx_power_level),
    .frame_start_irq(fs_irq), .frame_end_irq(fe_irq), .buffer_underrun_irq(ur_irq),
    .underrun_valid(ur_valid));
  baseband_model bb (
    .bb_clk(bb_clk), .bb_rx_start(bb_rx_start), .bb_rx_valid(bb_rx_valid),
    .bb_rx_end(bb_rx_end), .bb_rx_byte(bb_rx_byte), .bb_rx_len(bb_rx_len),
    .bb_lqi(bb_lqi), .bb_tx_req(bb_tx_req));
  // Counts and reports one comparison
  task check(input [32:0] got, input [32:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Verdict and end of run
  task summarize;
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task apb(input [31:0] a, input w, input [31:0] d);
    integer k;
    begin
      @(posedge ref_clk);
      psel    <= 1'b1;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do begin
        @(posedge ref_clk);
        k = k + 1;
      end while (pready !== 1'b1 && k < 40);
      if (k >= 40) begin
        check(33'h1, 33'h0);
        summarize;
      end
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [31:0] a, input [31:0] d); apb(a, 1'b1, d); endtask
  task rd(input [31:0] a, input [32:0] e);
    begin
      rdq.push_back(e);
      apb(a, 1'b0, 32'h0);
    end
  endtask
  // Reflected checksum over one byte
  function [15:0] crc_step(input [15:0] c, input [7:0] d);
    integer j;
    begin
      crc_step = c;
      for (j = 0; j < 8; j = j + 1)
        crc_step = (crc_step[0] ^ d[j]) ? (crc_step >> 1) ^ 16'h8408 : crc_step >> 1;
    end
  endfunction
  // Output watcher takes the oldest expectation
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      check({pslverr, prdata}, rdq.size() ? rdq.pop_front() : 33'h1FFFFFFFF);
    if (tx_strobe === 1'b1)
      check({25'h0, tx_byte}, txq.size() ? {25'h0, txq.pop_front()} : 33'h1FFFFFFFF);
    // Interrupt pulses counted for later checks
    if (ur_irq === 1'b1)
      n_ur = n_ur + 1;
    if (fs_irq === 1'b1)
      n_fs = n_fs + 1;
    if (fe_irq === 1'b1)
      n_fe = n_fe + 1;
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(32'h14, 33'h0);
    rd(32'h28, 33'h0);
    rd(32'h3C, 33'h100000000);
    for (i = 0; i < 4; i = i + 1) begin
      b[0] = $random(seed);
      wr(32'h14, {24'h0, b[0]});
      @(negedge ref_clk);
      check({29'h0, tx_power_level}, {29'h0, b[0][3:0]});
      rd(32'h14, {25'h0, b[0]});
    end
    for (i = 0; i < 4; i = i + 1) b[i] = $random(seed);
    wr(32'h20, 32'h1);
    wr(32'h24, 32'h3);
    for (i = 0; i < 3; i = i + 1) wr(32'h24, {24'h0, b[i]});
    wr(32'h20, 32'h1);
    rd(32'h24, 33'h3);
    for (i = 0; i < 3; i = i + 1) rd(32'h24, {25'h0, b[i]});
    rd(32'h28, 33'h302);
    wr(32'h20, 32'h0103);
    rd(32'h24, {25'h0, b[1]});
    rd(32'h24, {25'h0, b[2]});
    wr(32'h14, 32'h80);
    wr(32'h20, 32'h1);
    wr(32'h24, 32'h3);
    wr(32'h24, {24'h0, b[3]});
    crc = crc_step(16'h0000, b[3]);
    txq.push_back(b[3]);
    txq.push_back(crc[7:0]);
    txq.push_back(crc[15:8]);
    trig <= 1'b1;
    repeat (10) @(posedge ref_clk);
    // Late rewrite while transmit waits at address 0: write violation
    wr(32'h20, 32'h1);
    wr(32'h24, 32'h3);
    wr(32'h24, {24'h0, b[3]});
    rd(32'h28, 33'h303);
    check({1'b0, n_ur}, 33'h1);
    wr(32'h28, 32'h1);
    rd(32'h28, 33'h302);
    bb.tx_pull(3);
    trig <= 1'b0;
    for (i = 0; i < 60 && txq.size() > 0; i = i + 1) @(posedge ref_clk);
    check({32'h0, txq.size() != 0}, 33'h0);
    rx_en <= 1'b1;
    for (i = 0; i < 2; i = i + 1) begin
      aret <= i[0];
      repeat (12) @(posedge ref_clk);
      bb.rx_frame(2, i ? 32'h0000A55A : {16'h0, b[1], b[0]}, b[2]);
      repeat (12) @(posedge ref_clk);
      wr(32'h20, 32'h1);
      rd(32'h24, 33'h2);
      rd(32'h24, {25'h0, b[0]});
      rd(32'h24, {25'h0, b[1]});
      rd(32'h24, {25'h0, b[2]});
    end
    check({1'b0, n_fs}, 33'h1);
    check({1'b0, n_fe}, 33'h1);
    rx_en <= 1'b0;
    aret  <= 1'b0;
    for (i = 0; i < 2; i = i + 1) begin
      slp <= !i[0];
      pon <= i[0];
      repeat (8) @(posedge ref_clk);
      rd(32'h24, 33'h100000000);
    end
    pon <= 1'b0;
    repeat (8) @(posedge ref_clk);
    wr(32'h20, 32'h1);
    rd(32'h24, 33'h0);
    summarize;
  end
endmodule // radio_frame_buffer_test
